//--- common/cpam_pkg.sv
`default_nettype none
package cpam_pkg;
  // line framing, fixed
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned CLK_HZ = 125_000_000;
  // supported line rates in bit/s
  localparam int unsigned RATE_MIN_BPS = 1200;
  localparam int unsigned RATE_MAX_BPS = 19200;
  localparam int unsigned NUM_RATES = 5;
  // bit periods in clock cycles for 1200, 2400, 4800, 9600, 19200
  localparam int unsigned DIV_1200 = CLK_HZ / 1200;
  localparam int unsigned DIV_2400 = CLK_HZ / 2400;
  localparam int unsigned DIV_4800 = CLK_HZ / 4800;
  localparam int unsigned DIV_9600 = CLK_HZ / 9600;
  localparam int unsigned DIV_19200 = CLK_HZ / 19200;
  localparam int unsigned DIV_W = 17;
  // idle timeout in manual mode
  localparam int unsigned IDLE_MIN = 30;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_MIN) * 60 * CLK_HZ;
  // characters
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CTRL_T = 8'h14;
  localparam logic [7:0] CH_DIGIT_1 = 8'h31;
  localparam logic [7:0] CH_DIGIT_9 = 8'h39;
  localparam logic [7:0] CH_ESC = 8'h1b;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [3:0] MENU_ITEMS = 4'h9;
  localparam logic [3:0] SEL_PROV = 4'h2;
  localparam logic [3:0] SEL_TERM = 4'h7;
  localparam int unsigned REFRESH_SPACES = 3;
  localparam int unsigned NUM_OPTS = 7;

  typedef enum logic [3:0] {
    CPAM_SCR_MAIN = 4'h0,
    CPAM_SCR_UNIT = 4'h1,
    CPAM_SCR_PROV = 4'h2,
    CPAM_SCR_SPAN = 4'h3,
    CPAM_SCR_LOOP = 4'h4,
    CPAM_SCR_PERF = 4'h5,
    CPAM_SCR_CID = 4'h6,
    CPAM_SCR_TERM = 4'h7,
    CPAM_SCR_ALARM = 4'h8,
    CPAM_SCR_EVENT = 4'h9,
    CPAM_SCR_SUB = 4'ha
  } cpam_screen_t;

  // request to the screen renderer
  typedef struct packed {
    cpam_screen_t screen;
    logic [3:0] option;
    logic live;
    logic banner;
    logic [6:0] mismatch;
  } cpam_draw_t;
endpackage : cpam_pkg
`default_nettype wire

//--- logic/cpam_rx.sv
`default_nettype none
// receiver with rate search on a space character
module cpam_rx (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // line
  input wire logic rxd,
  // control
  input wire logic relock,
  // status and data
  output logic locked,
  output logic [16:0] bit_div,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic [2:0] sync_reg;
  logic line_q;
  logic [16:0] cnt_reg;
  logic [3:0] bit_reg;
  logic busy_reg;
  logic [7:0] sh_reg;
  logic meas_reg;
  logic [16:0] meas_div;
  logic [16:0] near_div;
  // wide enough for six bit times at the slowest rate
  logic [19:0] meas_cnt_reg;
  // skips the tail of the search character after lock
  logic skip_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_reg <= 3'h7;
      line_q <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], rxd};
      if (sync_reg[2] == sync_reg[1]) begin
        line_q <= sync_reg[2];
      end
    end
  end

  // start bit plus five low data bits of 0x20 give six bit times low
  assign meas_div = 17'(meas_cnt_reg / 20'h6);
  always_comb begin
    near_div = 17'(cpam_pkg::DIV_1200);
    if (meas_div < 17'(cpam_pkg::DIV_19200 + cpam_pkg::DIV_19200 / 2)) begin
      near_div = 17'(cpam_pkg::DIV_19200);
    end else if (meas_div < 17'(cpam_pkg::DIV_9600 + cpam_pkg::DIV_9600 / 2)) begin
      near_div = 17'(cpam_pkg::DIV_9600);
    end else if (meas_div < 17'(cpam_pkg::DIV_4800 + cpam_pkg::DIV_4800 / 2)) begin
      near_div = 17'(cpam_pkg::DIV_4800);
    end else if (meas_div < 17'(cpam_pkg::DIV_2400 + cpam_pkg::DIV_2400 / 2)) begin
      near_div = 17'(cpam_pkg::DIV_2400);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      locked <= 1'b0;
      bit_div <= 17'(cpam_pkg::DIV_1200);
      meas_reg <= 1'b0;
      busy_reg <= 1'b0;
      meas_cnt_reg <= 20'h0;
      skip_reg <= 1'b0;
      cnt_reg <= 17'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h0;
      rx_data <= 8'h0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (relock) begin
        locked <= 1'b0;
        meas_reg <= 1'b0;
        busy_reg <= 1'b0;
        skip_reg <= 1'b0;
      end else if (!locked) begin
        // time the low run of a space, then choose nearest rate; see RULE13 see RULE3
        if (!meas_reg && !line_q) begin
          meas_reg <= 1'b1;
          meas_cnt_reg <= 20'h1;
        end else if (meas_reg && !line_q) begin
          if (meas_cnt_reg != 20'hfffff) begin
            meas_cnt_reg <= meas_cnt_reg + 20'h1;
          end
        end else if (meas_reg && line_q) begin
          meas_reg <= 1'b0;
          bit_div <= near_div; // see RULE2
          locked <= 1'b1;
          // last three data bits and stop of the space are not a character
          skip_reg <= 1'b1;
          cnt_reg <= near_div - 17'h1;
          bit_reg <= 4'h0;
        end
      end else if (skip_reg) begin
        if (cnt_reg != 17'h0) begin
          cnt_reg <= cnt_reg - 17'h1;
        end else if (bit_reg == 4'h3) begin
          skip_reg <= 1'b0; // see RULE13
        end else begin
          bit_reg <= bit_reg + 4'h1;
          cnt_reg <= bit_div - 17'h1;
        end
      end else if (!busy_reg) begin
        if (!line_q) begin
          busy_reg <= 1'b1;
          cnt_reg <= 17'(bit_div >> 1);
          bit_reg <= 4'h0;
        end
      end else if (cnt_reg != 17'h0) begin
        cnt_reg <= cnt_reg - 17'h1;
      end else begin
        // centre sample of each bit; see RULE14
        cnt_reg <= bit_div - 17'h1;
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h0) begin
          busy_reg <= !line_q;
        end else if (bit_reg <= 4'(cpam_pkg::DATA_BITS)) begin
          sh_reg <= {line_q, sh_reg[7:1]}; // see RULE1
        end else begin
          busy_reg <= 1'b0;
          rx_data <= sh_reg;
          rx_valid <= line_q; // see RULE14
        end
      end
    end
  end
endmodule : cpam_rx
`default_nettype wire

//--- logic/cpam_tx.sv
`default_nettype none
// transmitter with a two-entry skid buffer in front
module cpam_tx #(
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // rate
  input wire logic [16:0] bit_div,
  // character stream
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // line
  output logic txd,
  output logic tx_busy
);
  initial begin
    if (DEPTH != 2) $error("cpam_tx supports depth 2 only");
  end
  logic [7:0] buf_reg [2];
  logic [1:0] cnt_buf;
  logic rd_reg;
  logic wr_reg;
  logic [16:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [8:0] sh_reg;
  logic take;
  logic push;

  assign in_ready = (cnt_buf != 2'h2);
  assign push = in_valid && in_ready;
  assign take = !tx_busy && (cnt_buf != 2'h0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_buf <= 2'h0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      buf_reg[0] <= 8'h0;
      buf_reg[1] <= 8'h0;
    end else begin
      if (push) begin
        buf_reg[wr_reg] <= in_data;
        wr_reg <= !wr_reg;
      end
      if (take) begin
        rd_reg <= !rd_reg;
      end
      cnt_buf <= cnt_buf + 2'(push) - 2'(take);
    end
  end

  // start, eight data, one stop; see RULE1
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txd <= 1'b1;
      tx_busy <= 1'b0;
      cnt_reg <= 17'h0;
      bit_reg <= 4'h0;
      sh_reg <= 9'h1ff;
    end else if (take) begin
      tx_busy <= 1'b1;
      txd <= 1'b0;
      sh_reg <= {1'b1, buf_reg[rd_reg]};
      cnt_reg <= bit_div - 17'h1;
      bit_reg <= 4'h0;
    end else if (tx_busy) begin
      if (cnt_reg != 17'h0) begin
        cnt_reg <= cnt_reg - 17'h1;
      end else if (bit_reg == 4'(cpam_pkg::DATA_BITS + 1)) begin
        tx_busy <= 1'b0;
      end else begin
        txd <= sh_reg[0];
        sh_reg <= {1'b1, sh_reg[8:1]};
        bit_reg <= bit_reg + 4'h1;
        cnt_reg <= bit_div - 17'h1;
      end
    end
  end
endmodule : cpam_tx
`default_nettype wire

//--- logic/cpam_top.sv
`default_nettype none
// Overview of operation
// RULE1 - characters use eight data bits, no parity and one stop bit, with no option to change it.
// RULE2 - the port runs at any supported rate from 1200 to 19200 bit/s.
// RULE3 - a session opens with spaces whose timing fixes the rate before anything is sent.
// RULE4 - after lock the main menu with its nine selections is drawn.
// RULE5 - a selection digit on the main menu opens its screen.
// RULE6 - after reset the display is live, and manual only when chosen.
// RULE7 - in manual mode a banner tops each screen and three spaces redraw it.
// RULE8 - live mode sends highlight and cursor sequences, manual mode plain text.
// RULE9 - an option digit on the provisioning screen opens its list of settings.
// RULE10 - an option set through the port that differs from its switch is starred.
// RULE11 - in manual mode thirty idle minutes drop the rate and restart the search.
// RULE12 - control-T on any screen toggles live and manual modes.
// RULE13 - the search times a received 0x20 and picks the nearest rate before taking more input.
// RULE14 - bits are sampled at centre and a character with a low stop bit is dropped.
module cpam_top #(
  parameter longint unsigned IDLE_CYCLES = cpam_pkg::IDLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial line
  input wire logic rxd,
  output logic txd,
  // option state: switch settings and port settings, one bit per option
  input wire logic [6:0] switch_opts,
  input wire logic [6:0] port_opts,
  // screen renderer: draw request out, characters back
  output var cpam_pkg::cpam_draw_t draw,
  output logic draw_start,
  input wire logic draw_busy,
  input wire logic [7:0] char_data,
  input wire logic char_valid,
  output logic char_ready,
  // status
  output logic locked,
  output logic live_mode
);
  initial begin
    if (IDLE_CYCLES < 64'h1) $error("idle count must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic relock;
  logic [16:0] bit_div;
  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_busy;
  logic tx_ready;
  logic [1:0] space_cnt_reg;
  logic [63:0] idle_reg;
  logic locked_q;
  logic [7:0] last_char_reg;
  logic last_esc;
  logic last_esc_reg;
  logic rx_digit;
  logic [3:0] digit;
  logic redraw;
  logic live_next;

  cpam_rx u_rx (
    .clk(clk),
    .reset(reset),
    .rxd(rxd),
    .relock(relock),
    .locked(locked),
    .bit_div(bit_div),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  // drop escape sequences while in manual mode; see RULE8
  assign last_esc = (char_data == cpam_pkg::CH_ESC);
  logic pass_char;
  logic in_seq;
  assign in_seq = last_esc || last_esc_reg;
  assign pass_char = live_mode || !in_seq;
  assign char_ready = !locked ? 1'b0 : (pass_char ? tx_ready : 1'b1); // see RULE3

  cpam_tx #(
    .DEPTH(2)
  ) u_tx (
    .clk(clk),
    .reset(reset),
    .bit_div(bit_div),
    .in_data(char_data),
    .in_valid(char_valid && locked && pass_char),
    .in_ready(tx_ready),
    .txd(txd),
    .tx_busy(tx_busy)
  );

  // escape sequences run from ESC to the first letter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_esc_reg <= 1'b0;
      last_char_reg <= 8'h0;
    end else if (char_valid && char_ready) begin
      last_char_reg <= char_data;
      if (last_esc) begin
        last_esc_reg <= 1'b1;
      end else if (char_data[6] && char_data[4:0] != 5'h0 && char_data[4:0] <= 5'h1a) begin
        last_esc_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rx_digit = rx_valid && rx_data >= cpam_pkg::CH_DIGIT_1 && rx_data <= cpam_pkg::CH_DIGIT_9;
  assign digit = rx_data[3:0];

  // display mode; the draw request carries the new mode; see RULE6 see RULE12
  always_comb begin
    live_next = live_mode;
    if (rx_valid && rx_data == cpam_pkg::CH_CTRL_T) begin
      live_next = !live_mode;
    end else if (rx_digit && draw.screen == cpam_pkg::CPAM_SCR_TERM && digit <= 4'h2) begin
      live_next = (digit == 4'h2);
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      live_mode <= 1'b1;
    end else begin
      live_mode <= live_next;
    end
  end

  // three spaces request a redraw in manual mode; see RULE7
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      space_cnt_reg <= 2'h0;
    end else if (rx_valid) begin
      if (rx_data != cpam_pkg::CH_SPACE || live_mode) begin
        space_cnt_reg <= 2'h0;
      end else if (space_cnt_reg == 2'(cpam_pkg::REFRESH_SPACES - 1)) begin
        space_cnt_reg <= 2'h0;
      end else begin
        space_cnt_reg <= space_cnt_reg + 2'h1;
      end
    end
  end
  assign redraw = rx_valid && !live_mode && rx_data == cpam_pkg::CH_SPACE
    && space_cnt_reg == 2'(cpam_pkg::REFRESH_SPACES - 1);

  // idle timer restarts the rate search; see RULE11
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_reg <= 64'h0;
    end else if (rx_valid || live_mode || !locked) begin
      idle_reg <= 64'h0;
    end else if (idle_reg != IDLE_CYCLES) begin
      idle_reg <= idle_reg + 64'h1;
    end
  end
  assign relock = (idle_reg == IDLE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // screen selection and draw requests
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      locked_q <= 1'b0;
      draw <= '0;
      draw_start <= 1'b0;
    end else begin
      locked_q <= locked;
      draw_start <= 1'b0;
      draw.live <= live_next; // see RULE8
      draw.banner <= !live_next; // see RULE7
      draw.mismatch <= switch_opts ^ port_opts; // see RULE10
      if (locked && !locked_q) begin
        draw.screen <= cpam_pkg::CPAM_SCR_MAIN; // see RULE4
        draw_start <= 1'b1;
      end else if (rx_valid && rx_data == cpam_pkg::CH_ESC) begin
        draw.screen <= cpam_pkg::CPAM_SCR_MAIN;
        draw_start <= 1'b1;
      end else if (rx_digit && draw.screen == cpam_pkg::CPAM_SCR_MAIN && digit <= cpam_pkg::MENU_ITEMS) begin
        draw.screen <= cpam_pkg::cpam_screen_t'(digit); // see RULE5
        draw_start <= 1'b1;
      end else if (rx_digit && draw.screen == cpam_pkg::CPAM_SCR_PROV
          && digit <= 4'(cpam_pkg::NUM_OPTS)) begin
        draw.screen <= cpam_pkg::CPAM_SCR_SUB; // see RULE9
        draw.option <= digit;
        draw_start <= 1'b1;
      end else if (redraw || (rx_valid && rx_data == cpam_pkg::CH_CTRL_T)) begin
        draw_start <= 1'b1; // see RULE7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  main_menu_a: assert property (@(posedge clk) disable iff (reset)
    $rose(locked) |=> draw_start && draw.screen == cpam_pkg::CPAM_SCR_MAIN) // see RULE4
    else $error("main menu not drawn after lock");

  screen_open_a: assert property (@(posedge clk) disable iff (reset)
    rx_digit && draw.screen == cpam_pkg::CPAM_SCR_MAIN && !$rose(locked) && rx_data != cpam_pkg::CH_ESC
    |=> draw.screen == cpam_pkg::cpam_screen_t'($past(digit))) // see RULE5
    else $error("selection did not open screen");

  sub_menu_a: assert property (@(posedge clk) disable iff (reset)
    rx_digit && draw.screen == cpam_pkg::CPAM_SCR_PROV && digit <= 4'h7 && !$rose(locked)
    |=> draw.screen == cpam_pkg::CPAM_SCR_SUB && draw_start) // see RULE9
    else $error("option submenu not opened");

  mode_toggle_a: assert property (@(posedge clk) disable iff (reset)
    rx_valid && rx_data == cpam_pkg::CH_CTRL_T |=> live_mode != $past(live_mode)) // see RULE12
    else $error("control-T did not toggle mode");

  sequence three_spaces_s;
    redraw;
  endsequence
  refresh_a: assert property (@(posedge clk) disable iff (reset)
    three_spaces_s |=> draw_start) // see RULE7
    else $error("no redraw after three spaces");

  plain_text_a: assert property (@(posedge clk) disable iff (reset)
    !live_mode && u_tx.push |-> char_data != cpam_pkg::CH_ESC) // see RULE8
    else $error("escape sent in manual mode");

  quiet_search_a: assert property (@(posedge clk) disable iff (reset)
    !locked |=> txd && !tx_busy || $past(tx_busy)) // see RULE3
    else $error("transmit before lock");

  mark_a: assert property (@(posedge clk) disable iff (reset)
    ##1 draw.mismatch == ($past(switch_opts) ^ $past(port_opts))) // see RULE10
    else $error("mismatch mark wrong");

  idle_drop_a: assert property (@(posedge clk) disable iff (reset)
    relock |=> !locked) // see RULE11
    else $error("idle timeout did not drop lock");

  stop_check_a: assert property (@(posedge clk) disable iff (reset)
    rx_valid |-> u_rx.line_q) // see RULE14
    else $error("character kept with low stop bit");
endmodule : cpam_top
`default_nettype wire

//--- verif/cpam_term.sv
`default_nettype none
// operator terminal: sends characters on rxd, decodes frames seen on txd
module cpam_term (
  // clock
  input wire logic clk,
  // line
  output logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = cpam_pkg::DIV_19200;
  logic [7:0] rx_q[$];
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // one frame of d cycles a bit, lsb first, no parity; stop level given
  task automatic send(input logic [7:0] b, input int d, input logic stop);
    int i;
    @(negedge clk);
    rxd = 1'b0;
    repeat (d) @(negedge clk);
    for (i = 0; i < 8; i++) begin
      rxd = b[i];
      repeat (d) @(negedge clk);
    end
    rxd = stop;
    repeat (d) @(negedge clk);
    rxd = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // receiver samples at mid bit; frames with a low stop bit are dropped
  always begin : decode
    logic [7:0] v;
    int i;
    @(negedge clk);
    if (txd === 1'b0) begin
      repeat (div / 2) @(negedge clk);
      for (i = 0; i < 8; i++) begin
        repeat (div) @(negedge clk);
        v[i] = txd;
      end
      repeat (div) @(negedge clk);
      if (txd === 1'b1) begin
        rx_q.push_back(v);
      end
    end
  end
endmodule // cpam_term
`default_nettype wire

//--- verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint unsigned IDLE_SIM = 200000;
  localparam int D19 = cpam_pkg::DIV_19200;
  localparam int D96 = cpam_pkg::DIV_9600;
  logic clk, reset, rxd, txd, draw_start, draw_busy, char_valid, char_ready, locked, live_mode, refused;
  logic [6:0] switch_opts, port_opts;
  logic [7:0] char_data;
  cpam_pkg::cpam_draw_t draw, last_draw;
  int failures, num_checks, n_draw, n0, i;
  longint cyc, t_last;
  logic [7:0] seq [4];

  cpam_top #(.IDLE_CYCLES(IDLE_SIM)) dut (.clk(clk), .reset(reset), .rxd(rxd), .txd(txd),
    .switch_opts(switch_opts), .port_opts(port_opts), .draw(draw), .draw_start(draw_start),
    .draw_busy(draw_busy), .char_data(char_data), .char_valid(char_valid), .char_ready(char_ready),
    .locked(locked), .live_mode(live_mode));
  cpam_term term (.clk(clk), .rxd(rxd), .txd(txd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc++;
  // draw requests are one-cycle pulses: count them and keep the last
  always @(negedge clk) begin
    if (draw_start === 1'b1) begin
      n_draw++;
      last_draw = draw;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rx(input logic [7:0] b, input logic stop);
    term.send(b, term.div, stop);
    repeat (300) @(negedge clk);
  endtask
  // holds valid and data until the edge that takes them
  task automatic push(input logic [7:0] b);
    int k;
    char_data = b;
    char_valid = 1'b1;
    for (k = 0; k < 100000 && char_ready !== 1'b1; k++) begin
      refused = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
  endtask
  task automatic got(input logic [7:0] b, input string msg);
    int k;
    for (k = 0; k < 12 * term.div && term.rx_q.size() == 0; k++) begin
      @(negedge clk);
    end
    check(16'(term.rx_q.size() > 0 ? term.rx_q.pop_front() : 9'h1ff), 16'(b), msg);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(16'(txd), 16'h1, "idle line");
    check(16'(locked), 16'h0, "unlocked");
    check(16'(live_mode), 16'h1, "live mode");
    check(16'(char_ready), 16'h0, "no send before lock");
    $display("test reset done");
  endtask
  task automatic t_lock();
    n0 = n_draw;
    rx(cpam_pkg::CH_SPACE, 1'b1);
    check(16'(locked), 16'h1, "locked");
    check(16'(n_draw - n0), 16'h1, "menu draw");
    check(16'(last_draw.screen), 16'(cpam_pkg::CPAM_SCR_MAIN), "menu screen");
    check(16'(last_draw.live), 16'h1, "live draw");
    $display("test lock done");
  endtask
  task automatic t_tx_live();
    seq = '{8'h1b, 8'h5b, 8'h31, 8'h48};
    refused = 1'b0;
    for (i = 0; i < 4; i++) begin
      push(seq[i]);
    end
    char_valid = 1'b0;
    check(16'(refused), 16'h1, "buffer full refuses");
    for (i = 0; i < 4; i++) begin
      got(seq[i], "live char");
    end
    $display("test tx_live done");
  endtask
  task automatic t_select();
    switch_opts = 7'h05;
    port_opts = 7'h11;
    n0 = n_draw;
    rx(8'h32, 1'b1);
    check(16'(last_draw.screen), 16'(cpam_pkg::CPAM_SCR_PROV), "prov screen");
    check(16'(last_draw.mismatch), 16'h14, "starred options");
    n0 = n_draw;
    rx(8'h33, 1'b0);
    repeat (11 * D19) @(negedge clk);
    check(16'(n_draw - n0), 16'h0, "bad stop dropped");
    rx(8'h33, 1'b1);
    check(16'(n_draw - n0), 16'h1, "sub draw");
    check(16'(last_draw.screen), 16'(cpam_pkg::CPAM_SCR_SUB), "sub screen");
    check(16'(last_draw.option), 16'h3, "sub option");
    $display("test select done");
  endtask
  task automatic t_manual();
    n0 = n_draw;
    rx(cpam_pkg::CH_CTRL_T, 1'b1);
    check(16'(live_mode), 16'h0, "toggled");
    check(16'(n_draw - n0), 16'h1, "toggle draw");
    check(16'(last_draw.banner), 16'h1, "banner");
    check(16'(last_draw.live), 16'h0, "plain draw");
    for (i = 0; i < 3; i++) begin
      n0 = n_draw;
      rx(cpam_pkg::CH_SPACE, 1'b1);
      check(16'(n_draw - n0), 16'(i == 2), "redraw on third");
    end
    t_last = cyc;
    seq = '{8'h1b, 8'h5b, 8'h6d, 8'h5a};
    for (i = 0; i < 4; i++) begin
      push(seq[i]);
    end
    char_valid = 1'b0;
    got(8'h5a, "escape swallowed");
    $display("test manual done");
  endtask
  task automatic t_idle();
    check(16'(locked), 16'h1, "still locked");
    for (i = 0; i < IDLE_SIM && locked === 1'b1; i++) begin
      @(negedge clk);
    end
    check(16'((cyc - t_last) >= IDLE_SIM - 2 * D19 && (cyc - t_last) <= IDLE_SIM), 16'h1, "idle time");
    check(16'(locked), 16'h0, "lock dropped");
    $display("test idle done");
  endtask
  task automatic t_relock();
    term.div = D96;
    n0 = n_draw;
    rx(cpam_pkg::CH_SPACE, 1'b1);
    check(16'(locked), 16'h1, "relocked");
    check(16'(last_draw.screen), 16'(cpam_pkg::CPAM_SCR_MAIN), "menu again");
    push(8'h4b);
    char_valid = 1'b0;
    got(8'h4b, "char at slower rate");
    $display("test relock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    char_data = 8'h00;
    char_valid = 1'b0;
    switch_opts = 7'h00;
    port_opts = 7'h00;
    draw_busy = 1'b0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_reset();
    t_lock();
    t_tx_live();
    t_select();
    t_manual();
    t_idle();
    t_relock();
    final_report();
  end
  // the sequence needs about 1.3 million cycles at these rates
  initial begin
    repeat (3000000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
